// *** dpr_pkg.sv ***
// Constants shared by the dual-port memory block and its APB registers.
// Assumes one 50 MHz system clock; memory clocks arrive as enable ticks.
//
// Functional notes
// - Single clock method: clock A ticks every register.
// - In/out method: input tick clocks all inputs.
// - In/out method: output tick clocks read data only.
// - Read/write method: write tick clocks write registers.
// - Read/write method: read tick clocks read registers.
// - Per-port method: tick A clocks port A registers.
// - Per-port method: tick B clocks port B registers.
// - Per-port method: each port has own clock enable.
// - One-read-one-write: optional single read enable.
// - Two read/write ports: optional per-port read enables.
// - Byte enables write only selected bytes.
// - Write inputs, read inputs, outputs registered separately.
`default_nettype none

package dpr_pkg;

  // ----------------------------------------------------------------
  // Clock and APB map
  // ----------------------------------------------------------------
  localparam int REF_CLK_MHZ = 50;
  localparam int APB_AW = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_METHOD_LSB = 0;
  localparam int CTRL_TWO_RW = 2;
  localparam int CTRL_RDEN_ON = 3;
  localparam int CTRL_BYTEEN_ON = 4;
  localparam int CTRL_REG_WIN = 5;
  localparam int CTRL_REG_RIN = 6;
  localparam int CTRL_REG_OUT = 7;
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'hE0;

  // ----------------------------------------------------------------
  // Status layout: write counters of port A and port B
  // ----------------------------------------------------------------
  localparam int STAT_CNT_W = 16;

  // Clocking methods
  typedef enum logic [1:0] {
    DPR_CLK_SINGLE = 2'b00,
    DPR_CLK_IN_OUT = 2'b01,
    DPR_CLK_RD_WR = 2'b10,
    DPR_CLK_PER_PORT = 2'b11
  } dpr_clk_method_t;

endpackage

`default_nettype wire

// *** dpr_in_stage.sv ***
// Optional input register stage for one memory port.
// Assumes the enable is a one-cycle tick of the selected memory clock.
`timescale 1ns/100ps
`default_nettype none

module dpr_in_stage
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic en,
  input wire logic regd,
  // Data
  input wire logic [WIDTH-1:0] live,
  output logic [WIDTH-1:0] sel
);

  logic [WIDTH-1:0] held;

  // Capture on the port tick; the memory sees it one tick later
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      held <= '0;
    else if (en)
      held <= live;
  end

  // Bypass when the stage is switched off
  assign sel = regd ? held : live;

endmodule // dpr_in_stage

`default_nettype wire

// *** dpr_mem_core.sv ***
// True dual-port memory array with per-byte write masks.
// Assumes both ports are stepped by enable ticks of one system clock.
`timescale 1ns/100ps
`default_nettype none

module dpr_mem_core
#(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8,
  parameter int BYTE_W = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Port A
  input wire logic en_a,
  input wire logic we_a,
  input wire logic re_a,
  input wire logic [DATA_W/BYTE_W-1:0] be_a,
  input wire logic [ADDR_W-1:0] addr_a,
  input wire logic [DATA_W-1:0] din_a,
  output logic [DATA_W-1:0] dout_a,
  // Port B
  input wire logic en_b,
  input wire logic we_b,
  input wire logic re_b,
  input wire logic [DATA_W/BYTE_W-1:0] be_b,
  input wire logic [ADDR_W-1:0] addr_b,
  input wire logic [DATA_W-1:0] din_b,
  output logic [DATA_W-1:0] dout_b
);

  localparam int NB = DATA_W / BYTE_W;

  wire [DATA_W-1:0] word_a;
  wire [DATA_W-1:0] word_b;

  // One array per byte lane so each array has a single writer process;
  // port B wins a same-address clash
  for (genvar i = 0; i < NB; i++)
  begin : g_lane
    logic [BYTE_W-1:0] lane [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk)
    begin
      if (en_a && we_a && be_a[i])
        lane[addr_a] <= din_a[i*BYTE_W +: BYTE_W];
      if (en_b && we_b && be_b[i])
        lane[addr_b] <= din_b[i*BYTE_W +: BYTE_W];
    end

    // Lane read taps feed the read latches below
    assign word_a[i*BYTE_W +: BYTE_W] = lane[addr_a];
    assign word_b[i*BYTE_W +: BYTE_W] = lane[addr_b];
  end

  // Read latches; old data is returned on a read during write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dout_a <= '0;
      dout_b <= '0;
    end
    else
    begin
      if (en_a && re_a)
        dout_a <= word_a;
      if (en_b && re_b)
        dout_b <= word_b;
    end
  end

endmodule // dpr_mem_core

`default_nettype wire

// *** dpr_top.sv ***
// Dual-port embedded memory with selectable clocking and registering.
// Assumes memory clocks arrive as one-cycle ticks synchronous to REF_CLK,
// and that software sets CTRL while the ports are idle.
`timescale 1ns/100ps
`default_nettype none

module dpr_top
  import dpr_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8,
  parameter int BYTE_W = 8
)
(
  // System clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dpr_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Memory clock ticks and their clock enables
  input wire logic TICK_A,
  input wire logic TICK_B,
  input wire logic CKEN_A,
  input wire logic CKEN_B,
  // Port A (write port in one-read-one-write form)
  input wire logic [ADDR_W-1:0] A_ADDR,
  input wire logic [DATA_W-1:0] A_DATA,
  input wire logic A_WREN,
  input wire logic A_RDEN,
  input wire logic [DATA_W/BYTE_W-1:0] A_BYTEEN,
  output logic [DATA_W-1:0] A_Q,
  // Port B (read port in one-read-one-write form)
  input wire logic [ADDR_W-1:0] B_ADDR,
  input wire logic [DATA_W-1:0] B_DATA,
  input wire logic B_WREN,
  input wire logic B_RDEN,
  input wire logic [DATA_W/BYTE_W-1:0] B_BYTEEN,
  output logic [DATA_W-1:0] B_Q
);

  import dpr_pkg::*;

  localparam int NB = DATA_W / BYTE_W;
  localparam int IN_W = ADDR_W + DATA_W + NB + 2;

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [STAT_CNT_W-1:0] wr_cnt_a;
  logic [STAT_CNT_W-1:0] wr_cnt_b;
  logic [31:0] next_prdata;

  wire apb_setup = PSEL && !PENABLE;
  wire apb_done = PSEL && PENABLE && PREADY;
  wire hit_ctrl = (PADDR == OFS_CTRL);
  wire hit_stat = (PADDR == OFS_STATUS);
  wire hit_any = hit_ctrl || hit_stat;
  wire ctrl_wr = apb_done && PWRITE && hit_ctrl;

  // Read data is chosen in the setup cycle so PRDATA leaves a flop
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl)
      next_prdata = {{(32-CTRL_W){1'b0}}, ctrl};
    else if (hit_stat)
      next_prdata = {wr_cnt_b, wr_cnt_a};
  end

  // Fixed one-cycle access phase; unmapped addresses answer an error
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end
    else
    begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup && !hit_any;
      // Refused writes also clear PRDATA so an error never shows data
      if (apb_setup && (!PWRITE || !hit_any))
        PRDATA <= next_prdata;
    end
  end

  // Configuration register; status is read only
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      ctrl <= CTRL_RESET;
    else if (ctrl_wr)
      ctrl <= PWDATA[CTRL_W-1:0];
  end

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  dpr_clk_method_t method;
  assign method = dpr_clk_method_t'(ctrl[CTRL_METHOD_LSB +: 2]);

  wire two_rw = ctrl[CTRL_TWO_RW];
  wire rden_on = ctrl[CTRL_RDEN_ON];
  wire byteen_on = ctrl[CTRL_BYTEEN_ON];
  wire reg_win = ctrl[CTRL_REG_WIN];
  wire reg_rin = ctrl[CTRL_REG_RIN];
  wire reg_out = ctrl[CTRL_REG_OUT];

  // Each memory clock is its tick qualified by its own clock enable
  wire clk_a = TICK_A && CKEN_A;
  wire clk_b = TICK_B && CKEN_B;

  // ----------------------------------------------------------------
  // Clock steering per register group
  // ----------------------------------------------------------------
  logic en_a_in;
  logic en_a_out;
  logic en_b_in;
  logic en_b_out;

  // Port A inputs always run on clock A; the other groups depend
  // on the method. Read/write form is meant for one-read-one-write.
  always_comb
  begin
    en_a_in = clk_a;
    en_a_out = clk_a;
    en_b_in = clk_a;
    en_b_out = clk_a;
    unique case (method)
      DPR_CLK_SINGLE:
      begin
        en_a_in = clk_a;
        en_a_out = clk_a;
        en_b_in = clk_a;
        en_b_out = clk_a;
      end
      DPR_CLK_IN_OUT:
      begin
        en_a_in = clk_a;
        en_b_in = clk_a;
        en_a_out = clk_b;
        en_b_out = clk_b;
      end
      DPR_CLK_RD_WR:
      begin
        en_a_in = clk_a;
        en_a_out = clk_a;
        en_b_in = clk_b;
        en_b_out = clk_b;
      end
      DPR_CLK_PER_PORT:
      begin
        en_a_in = clk_a;
        en_a_out = clk_a;
        en_b_in = clk_b;
        en_b_out = clk_b;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Port qualification
  // ----------------------------------------------------------------
  // Absent read enables read as always on; port roles follow the form
  wire rd_a_live = two_rw && (!rden_on || A_RDEN);
  wire rd_b_live = !rden_on || B_RDEN;
  wire wr_a_live = A_WREN;
  wire wr_b_live = two_rw && B_WREN;

  // Without byte enables every lane is written
  wire [NB-1:0] be_a_live = byteen_on ? A_BYTEEN : {NB{1'b1}};
  wire [NB-1:0] be_b_live = byteen_on ? B_BYTEEN : {NB{1'b1}};

  // ----------------------------------------------------------------
  // Optional input registers
  // ----------------------------------------------------------------
  logic [IN_W-1:0] in_a_sel;
  logic [IN_W-1:0] in_b_sel;

  // Port A carries the write inputs in either form
  wire reg_a_in = reg_win;
  // Port B carries the read inputs, or a full port in two-port form
  wire reg_b_in = two_rw ? reg_win : reg_rin;

  dpr_in_stage #(
    .WIDTH(IN_W)
  ) u_in_a (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .en(en_a_in),
    .regd(reg_a_in),
    .live({A_ADDR, A_DATA, be_a_live, wr_a_live, rd_a_live}),
    .sel(in_a_sel)
  );

  dpr_in_stage #(
    .WIDTH(IN_W)
  ) u_in_b (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .en(en_b_in),
    .regd(reg_b_in),
    .live({B_ADDR, B_DATA, be_b_live, wr_b_live, rd_b_live}),
    .sel(in_b_sel)
  );

  // Unpack the selected input words
  wire [ADDR_W-1:0] addr_a = in_a_sel[IN_W-1 -: ADDR_W];
  wire [DATA_W-1:0] din_a = in_a_sel[DATA_W+NB+1 : NB+2];
  wire [NB-1:0] be_a = in_a_sel[NB+1 : 2];
  wire we_a = in_a_sel[1];
  wire re_a = in_a_sel[0];
  wire [ADDR_W-1:0] addr_b = in_b_sel[IN_W-1 -: ADDR_W];
  wire [DATA_W-1:0] din_b = in_b_sel[DATA_W+NB+1 : NB+2];
  wire [NB-1:0] be_b = in_b_sel[NB+1 : 2];
  wire we_b = in_b_sel[1];
  wire re_b = in_b_sel[0];

  // ----------------------------------------------------------------
  // Memory array
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_a;
  logic [DATA_W-1:0] rd_b;

  dpr_mem_core #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W),
    .BYTE_W(BYTE_W)
  ) u_mem (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .en_a(en_a_in),
    .we_a(we_a),
    .re_a(re_a),
    .be_a(be_a),
    .addr_a(addr_a),
    .din_a(din_a),
    .dout_a(rd_a),
    .en_b(en_b_in),
    .we_b(we_b),
    .re_b(re_b),
    .be_b(be_b),
    .addr_b(addr_b),
    .din_b(din_b),
    .dout_b(rd_b)
  );

  // ----------------------------------------------------------------
  // Optional output registers and output flops
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] q_reg_a;
  logic [DATA_W-1:0] q_reg_b;

  // Output stage runs on the output clock and holds while reads are off
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      q_reg_a <= '0;
      q_reg_b <= '0;
    end
    else
    begin
      if (en_a_out && re_a)
        q_reg_a <= rd_a;
      if (en_b_out && re_b)
        q_reg_b <= rd_b;
    end
  end

  // Ports leave flops; costs one system cycle after the chosen source
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      A_Q <= '0;
      B_Q <= '0;
    end
    else
    begin
      A_Q <= reg_out ? q_reg_a : rd_a;
      B_Q <= reg_out ? q_reg_b : rd_b;
    end
  end

  // ----------------------------------------------------------------
  // Write counters shown in STATUS
  // ----------------------------------------------------------------
  // Counters wrap; they count accepted write ticks, not changed bytes
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wr_cnt_a <= '0;
      wr_cnt_b <= '0;
    end
    else
    begin
      if (en_a_in && we_a)
        wr_cnt_a <= wr_cnt_a + 1'b1;
      if (en_b_in && we_b)
        wr_cnt_b <= wr_cnt_b + 1'b1;
    end
  end

endmodule // dpr_top

`default_nettype wire

// *** dpr_properties.sv ***
// Checker for dpr_top: APB handshake and read data holds.
// Assumes it is bound to every dpr_top instance.
`timescale 1ns/100ps
`default_nettype none

module dpr_chk
#(
  parameter int DATA_W = 32
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Memory clocks and read data
  input wire logic TICK_A,
  input wire logic TICK_B,
  input wire logic CKEN_A,
  input wire logic CKEN_B,
  input wire logic [DATA_W-1:0] A_Q,
  input wire logic [DATA_W-1:0] B_Q
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // Quiet means no memory clock and no register access that could
  // change the output path
  wire logic no_tick = !(TICK_A & CKEN_A) & !(TICK_B & CKEN_B) & !PSEL;
  wire logic no_cken = !CKEN_A & !CKEN_B & !PSEL;
  wire logic setup = PSEL & !PENABLE;
  // Three quiet cycles drain every pending stage
  sequence quiet_s;
    no_tick [*3];
  endsequence
  sequence gated_s;
    no_cken [*3];
  endsequence
  ready_after_setup_a: assert property (setup |=> PREADY)
    else $error("ready missing after setup");
  ready_single_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  ready_in_access_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access phase");
  err_with_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  err_no_data_a: assert property (PSLVERR |-> PRDATA == 32'h0)
    else $error("data on refused access");
  b_q_hold_a: assert property (quiet_s |=> $stable(B_Q))
    else $error("port B output moved without clock");
  a_q_hold_a: assert property (quiet_s |=> $stable(A_Q))
    else $error("port A output moved without clock");
  cken_gate_a: assert property (gated_s |=> $stable(A_Q) && $stable(B_Q))
    else $error("output moved with enables low");
endmodule // dpr_chk

bind dpr_top dpr_chk #(.DATA_W(DATA_W)) u_chk (.REF_CLK(REF_CLK),
  .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .TICK_A(TICK_A), .TICK_B(TICK_B),
  .CKEN_A(CKEN_A), .CKEN_B(CKEN_B), .A_Q(A_Q), .B_Q(B_Q));

`default_nettype wire

// *** dpr_user_model.sv ***
// User-side clock source: memory clocks A and B as ticks.
// Assumes the bench owns run and slow.
`timescale 1ns/100ps
`default_nettype none

module dpr_user_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic run,
  input wire logic slow,
  // Ticks
  output logic tick_a,
  output logic tick_b
);
  logic phase;
  // Slow mode puts A and B on opposite cycles, like unrelated clocks
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase <= 1'b0;
      tick_a <= 1'b0;
      tick_b <= 1'b0;
    end
    else
    begin
      phase <= ~phase;
      tick_a <= run & (!slow | phase);
      tick_b <= run & (!slow | !phase);
    end
  end
endmodule // dpr_user_model

`default_nettype wire

// *** dpr_top_tb_top.sv ***
// Testbench for dpr_top: APB setup, random writes, clock gating.
// Assumes the checker is bound and the user model makes the ticks.
`timescale 1ns/100ps
`default_nettype none

module dpr_top_tb_top;
  import dpr_pkg::*;
  logic REF_CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, A_DATA, B_DATA, A_Q, B_Q, q, d;
  logic TICK_A, TICK_B, CKEN_A, CKEN_B, run, slow, err;
  logic A_WREN, A_RDEN, B_WREN, B_RDEN;
  logic [7:0] A_ADDR, B_ADDR, cfg;
  logic [3:0] A_BYTEEN, B_BYTEEN, be;
  logic [31:0] exp_mem [16];
  int n_mismatch, num_checks;

  dpr_top dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TICK_A(TICK_A), .TICK_B(TICK_B), .CKEN_A(CKEN_A), .CKEN_B(CKEN_B),
    .A_ADDR(A_ADDR), .A_DATA(A_DATA), .A_WREN(A_WREN), .A_RDEN(A_RDEN),
    .A_BYTEEN(A_BYTEEN), .A_Q(A_Q), .B_ADDR(B_ADDR), .B_DATA(B_DATA),
    .B_WREN(B_WREN), .B_RDEN(B_RDEN), .B_BYTEEN(B_BYTEEN), .B_Q(B_Q));
  dpr_user_model u_user (.clk(REF_CLK), .arst_n(ARST_N), .run(run),
    .slow(slow), .tick_a(TICK_A), .tick_b(TICK_B));

  // 50 MHz clock
  initial
  begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end

  task automatic final_report;
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a);
    int k = 0;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1 && ++k < 20);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK); // Idle edge keeps one driver step per signal
    if (k >= 20)
    begin
      n_mismatch++;
      final_report();
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask

  // Write held until the port's clock tick has been sampled
  task automatic mem_wr(input logic pb, input logic [7:0] a);
    int k = 0;
    if (pb)
      {B_ADDR, B_DATA, B_BYTEEN, B_WREN} <= {a, d, be, 1'b1};
    else
      {A_ADDR, A_DATA, A_BYTEEN, A_WREN} <= {a, d, be, 1'b1};
    do @(posedge REF_CLK); while (!(pb ? TICK_B : TICK_A) && ++k < 8);
    A_WREN <= 1'b0;
    B_WREN <= 1'b0;
    settle(12);
    if (k >= 8)
    begin
      n_mismatch++;
      final_report();
    end
  endtask

  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] m);
    for (int i = 0; i < 4; i++)
      if (m[i])
        o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction

  // Hang guard
  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, A_WREN, B_WREN} = '0;
    {A_ADDR, B_ADDR, A_DATA, B_DATA, A_BYTEEN, B_BYTEEN} = '0;
    {A_RDEN, B_RDEN, CKEN_A, CKEN_B, run, slow} = 6'h3E;
    {ARST_N, d, n_mismatch, num_checks} = '0;
    void'($urandom(63));
    settle(2);
    ARST_N <= 1'b1;
    @(posedge REF_CLK);
    apb(1'b0, OFS_CTRL);
    chk(q, {24'h0, CTRL_RESET});
    apb(1'b0, 12'h008);
    chk({q[31:1], err}, 32'h1);
    // Fill: single clock, byte enables on, nothing registered
    d = 32'h10;
    apb(1'b1, OFS_CTRL);
    be = 4'hF;
    for (int a = 0; a < 16; a++)
    begin
      d = $urandom;
      exp_mem[a] = d;
      mem_wr(1'b0, a[7:0]);
    end
    // Random masked writes over every method, with a random registering mix
    for (int i = 0; i < 8; i++)
    begin
      {run, CKEN_A, CKEN_B} <= 3'b0;
      settle(5);
      {run, CKEN_A, CKEN_B} <= 3'b111;
      slow <= i[2];
      cfg = {3'($urandom), 1'b1, 1'($urandom), 1'b0, 2'(i)};
      d = {24'h0, cfg};
      apb(1'b1, OFS_CTRL);
      apb(1'b0, OFS_CTRL);
      chk(q, {24'h0, cfg});
      B_ADDR <= 8'($urandom % 16);
      @(posedge REF_CLK);
      d = $urandom;
      be = (i == 0) ? 4'h0 : 4'($urandom);
      exp_mem[B_ADDR] = merge(exp_mem[B_ADDR], d, be);
      mem_wr(1'b0, B_ADDR);
      chk(B_Q, exp_mem[B_ADDR]);
    end
    // Two read/write ports, per-port clocks, read enables
    d = 32'h1F;
    apb(1'b1, OFS_CTRL);
    be = 4'hF;
    d = $urandom;
    exp_mem[1] = d;
    mem_wr(1'b1, 8'h01);
    A_ADDR <= 8'h01;
    settle(12);
    chk(A_Q, exp_mem[1]);
    CKEN_B <= 1'b0;
    d = ~d;
    mem_wr(1'b1, 8'h01);
    chk(A_Q, exp_mem[1]);
    CKEN_B <= 1'b1;
    A_RDEN <= 1'b0;
    A_ADDR <= 8'h02;
    settle(12);
    chk(A_Q, exp_mem[1]);
    A_RDEN <= 1'b1;
    settle(12);
    chk(A_Q, exp_mem[2]);
    // 24 port A writes; one port B write, the gated one not counted
    apb(1'b0, OFS_STATUS);
    chk(q, {16'h0001, 16'h0018});
    final_report();
  end
endmodule // dpr_top_tb_top

`default_nettype wire
